/* core/lbd_pkg.sv */
// constants, field layout and timing for the led bank serial driver
package lbd_pkg;
    // frame geometry
    localparam int FRAME_W = 36;
    localparam int BANK_W = 8;
    localparam int ADDR_W = 3;
    localparam int DUTY_W = 10;
    localparam int COARSE_W = 4;
    localparam int DIV_W = 4;
    // command field positions, bit 0 is the first bit shifted in
    localparam int F_ADDR_LO = 0;
    localparam int F_DUTY_A_LO = 3;
    localparam int F_DUTY_B_LO = 13;
    localparam int F_WD_DIS = 23;
    localparam int F_DIV_LO = 24;
    localparam int F_COARSE_A_LO = 28;
    localparam int F_COARSE_B_LO = 32;
    // status frame tail; revision value is arbitrary
    localparam int REV_W = 3;
    localparam int ALT_W = 15;
    localparam logic [REV_W-1:0] MASK_REV = 3'h1;
    localparam logic [ALT_W-1:0] ALT_PATTERN = 15'h5555;
    // timing at the core clock rate
    localparam int CLK_MHZ = 100;
    localparam int WD_TIMEOUT_US = 100;
    localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_US * CLK_MHZ;
    localparam int WD_CNT_W = 16;
    localparam int RAMP_STEP_US = 10;
    localparam int RAMP_STEP_CYC = RAMP_STEP_US * CLK_MHZ;
    localparam int RAMP_CNT_W = 10;
    // pwm phase offsets between neighbouring outputs
    localparam logic [DUTY_W-1:0] STAGGER_STEP = 10'h040;
    localparam logic [DUTY_W-1:0] STAGGER_B = 10'h020;
    // apb register map
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] ADDR_IRQ_STAT = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_IRQ_MASK = 12'h004;
    localparam logic [APB_AW-1:0] ADDR_FAULT = 12'h008;
    localparam logic [APB_AW-1:0] ADDR_CONFIG = 12'h00c;
    // interrupt bits
    localparam int IRQ_W = 4;
    localparam int IRQ_LATCH = 0;
    localparam int IRQ_WD = 1;
    localparam int IRQ_OPEN = 2;
    localparam int IRQ_THERM = 3;
    // latch sequence
    typedef enum logic [1:0] {LATCH_SHIFT, LATCH_COPIED, LATCH_HELD}
        lbd_latch_type;
endpackage

/* core/lbd_led_bank_driver.sv */
// serial-loaded dual bank pwm led driver with apb status and interrupts
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module lbd_led_bank_driver #(
    parameter int WD_CYC = lbd_pkg::WD_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [lbd_pkg::APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial link from the display controller
    input wire logic serial_shift_clock_i,
    input wire logic serial_data_in_i,
    input wire logic latch_strobe_i,
    output logic serial_data_out_o,
    // fault sense inputs
    input wire logic [lbd_pkg::BANK_W-1:0] open_sense_a_i,
    input wire logic [lbd_pkg::BANK_W-1:0] open_sense_b_i,
    input wire logic overtemp_i,
    // led drive
    output logic [lbd_pkg::BANK_W-1:0] bank_a_sink_output_o,
    output logic [lbd_pkg::BANK_W-1:0] bank_b_sink_output_o,
    output logic [lbd_pkg::COARSE_W-1:0] bank_a_base_drive_o,
    output logic [lbd_pkg::COARSE_W-1:0] bank_b_base_drive_o,
    // interrupt
    output logic irq_o
);
    import lbd_pkg::*;

    localparam logic [WD_CNT_W-1:0] WD_LIM = WD_CNT_W'(WD_CYC - 1);
    localparam logic [RAMP_CNT_W-1:0] RAMP_LIM =
        RAMP_CNT_W'(RAMP_STEP_CYC - 1);
    localparam logic [COARSE_W-1:0] RAMP_MAX = '1;

    logic sck_meta, sck_sync, sck_prev;
    logic din_meta, din_sync;
    logic lat_meta, lat_sync;
    logic ot_meta, ot_sync, ot_prev;
    logic [BANK_W-1:0] oa_meta, oa_sync, ob_meta, ob_sync;
    logic [FRAME_W-1:0] shift_reg;
    lbd_latch_type latch_reg;
    logic [DUTY_W-1:0] duty_a_mem [BANK_W];
    logic [DUTY_W-1:0] duty_b_mem [BANK_W];
    logic wd_dis_reg, loaded_reg;
    logic [DIV_W-1:0] div_reg, div_cnt_reg;
    logic [COARSE_W-1:0] coarse_a_reg, coarse_b_reg, ramp_reg;
    logic [RAMP_CNT_W-1:0] ramp_cnt_reg;
    logic [WD_CNT_W-1:0] wd_cnt_reg;
    logic wd_trip_reg;
    logic [DUTY_W-1:0] pwm_cnt_reg;
    logic [BANK_W-1:0] open_a_reg, open_b_reg;
    logic [BANK_W-1:0] sink_a_reg, sink_b_reg;
    logic [COARSE_W-1:0] base_a_reg, base_b_reg;
    logic sout_reg;
    logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;

    // two-stage synchronisers; only the second stage is read
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {sck_meta, sck_sync, sck_prev} <= 3'h0;
            {din_meta, din_sync, lat_meta, lat_sync} <= 4'h0;
            {ot_meta, ot_sync, ot_prev} <= 3'h0;
            {oa_meta, oa_sync, ob_meta, ob_sync} <= '0;
        end else begin
            sck_meta <= serial_shift_clock_i;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
            din_meta <= serial_data_in_i;
            din_sync <= din_meta;
            lat_meta <= latch_strobe_i;
            lat_sync <= lat_meta;
            ot_meta <= overtemp_i;
            ot_sync <= ot_meta;
            ot_prev <= ot_sync;
            oa_meta <= open_sense_a_i;
            oa_sync <= oa_meta;
            ob_meta <= open_sense_b_i;
            ob_sync <= ob_meta;
        end
    end

    // link edge detection and latch sequence decode
    wire logic sck_rise = sck_sync & ~sck_prev;
    wire logic sck_fall = ~sck_sync & sck_prev;
    wire logic shift_evt = sck_rise & ~lat_sync;
    // a single copy per strobe high period
    wire logic copy_evt = sck_fall & lat_sync &
        (latch_reg == LATCH_SHIFT);
    wire logic load_evt = sck_rise & lat_sync &
        (latch_reg == LATCH_COPIED);

    // command field extraction, first bit in lands in bit 0
    wire logic [ADDR_W-1:0] f_addr = shift_reg[F_ADDR_LO +: ADDR_W];
    wire logic [DUTY_W-1:0] f_duty_a = shift_reg[F_DUTY_A_LO +: DUTY_W];
    wire logic [DUTY_W-1:0] f_duty_b = shift_reg[F_DUTY_B_LO +: DUTY_W];
    wire logic f_wd_dis = shift_reg[F_WD_DIS];
    wire logic [DIV_W-1:0] f_div = shift_reg[F_DIV_LO +: DIV_W];
    wire logic [COARSE_W-1:0] f_coarse_a =
        shift_reg[F_COARSE_A_LO +: COARSE_W];
    wire logic [COARSE_W-1:0] f_coarse_b =
        shift_reg[F_COARSE_B_LO +: COARSE_W];

    // readback frame, open bits first out
    wire logic [FRAME_W-1:0] status_frame = {ALT_PATTERN, MASK_REV,
        ot_sync, wd_trip_reg, open_b_reg, open_a_reg};

    // shift register: serial in at the top, last stage at bit 0
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_reg <= '0;
        end else if (load_evt) begin
            shift_reg <= status_frame;
        end else if (shift_evt) begin
            shift_reg <= {din_sync, shift_reg[FRAME_W-1:1]};
        end
    end

    // last stage leaves toward the next device in the chain
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sout_reg <= 1'b0;
        end else begin
            sout_reg <= shift_reg[0];
        end
    end

    // latch sequence: copy on first fall, status on the next rise
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_reg <= LATCH_SHIFT;
        end else begin
            unique case (latch_reg)
                LATCH_SHIFT: begin
                    if (copy_evt) begin
                        latch_reg <= LATCH_COPIED;
                    end
                end
                LATCH_COPIED: begin
                    if (!lat_sync) begin
                        latch_reg <= LATCH_SHIFT;
                    end else if (sck_rise) begin
                        latch_reg <= LATCH_HELD;
                    end
                end
                LATCH_HELD: begin
                    if (!lat_sync) begin
                        latch_reg <= LATCH_SHIFT;
                    end
                end
            endcase
        end
    end

    // parallel register: per-output duty, per-bank coarse and globals
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int k = 0; k < BANK_W; k++) begin
                duty_a_mem[k] <= '0;
                duty_b_mem[k] <= '0;
            end
            {wd_dis_reg, div_reg, coarse_a_reg, coarse_b_reg} <= '0;
            loaded_reg <= 1'b0;
        end else if (copy_evt) begin
            duty_a_mem[f_addr] <= f_duty_a;
            duty_b_mem[f_addr] <= f_duty_b;
            wd_dis_reg <= f_wd_dis;
            div_reg <= f_div;
            coarse_a_reg <= f_coarse_a;
            coarse_b_reg <= f_coarse_b;
            loaded_reg <= 1'b1;
        end
    end

    // watchdog: any link edge restarts the count and ends a trip
    wire logic sck_edge = sck_rise | sck_fall;
    wire logic wd_expire = (wd_cnt_reg == WD_LIM) & ~wd_dis_reg;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wd_cnt_reg <= '0;
            wd_trip_reg <= 1'b0;
        end else if (sck_edge) begin
            wd_cnt_reg <= '0;
            wd_trip_reg <= 1'b0;
        end else if (!wd_trip_reg) begin
            wd_cnt_reg <= wd_expire ? '0 : wd_cnt_reg + 1'b1;
            wd_trip_reg <= wd_expire;
        end
    end

    // drive enable; thermal and watchdog blank every output
    wire logic drive_en =
        loaded_reg & ~wd_trip_reg & ~ot_sync;

    // soft start ramp restarts whenever drive is blanked
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ramp_reg <= '0;
            ramp_cnt_reg <= '0;
        end else if (!drive_en) begin
            ramp_reg <= '0;
            ramp_cnt_reg <= '0;
        end else if (ramp_reg != RAMP_MAX) begin
            ramp_cnt_reg <=
                (ramp_cnt_reg == RAMP_LIM) ? '0 : ramp_cnt_reg + 1'b1;
            if (ramp_cnt_reg == RAMP_LIM) begin
                ramp_reg <= ramp_reg + 1'b1;
            end
        end
    end

    // coarse level limited by the ramp while it climbs
    wire logic [COARSE_W-1:0] eff_a =
        (coarse_a_reg < ramp_reg) ? coarse_a_reg : ramp_reg;
    wire logic [COARSE_W-1:0] eff_b =
        (coarse_b_reg < ramp_reg) ? coarse_b_reg : ramp_reg;

    // pwm timebase, advanced once every divisor plus one cycles
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_reg <= '0;
            pwm_cnt_reg <= '0;
        end else if (div_cnt_reg >= div_reg) begin
            div_cnt_reg <= '0;
            pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // per-output compare on a shifted phase so turn-on edges never coincide
    wire logic [BANK_W-1:0] on_a, on_b;
    genvar gi;
    generate
        for (gi = 0; gi < BANK_W; gi++) begin : g_out
            localparam logic [DUTY_W-1:0] OFS_A = DUTY_W'(gi * STAGGER_STEP);
            localparam logic [DUTY_W-1:0] OFS_B =
                DUTY_W'(gi * STAGGER_STEP + STAGGER_B);
            wire logic [DUTY_W-1:0] ph_a = DUTY_W'(pwm_cnt_reg + OFS_A);
            wire logic [DUTY_W-1:0] ph_b = DUTY_W'(pwm_cnt_reg + OFS_B);
            assign on_a[gi] = ph_a < duty_a_mem[gi];
            assign on_b[gi] = ph_b < duty_b_mem[gi];
        end
    endgenerate

    // registered drive outputs, also a zero coarse level when blanked
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sink_a_reg <= '0;
            sink_b_reg <= '0;
            base_a_reg <= '0;
            base_b_reg <= '0;
        end else begin
            sink_a_reg <= on_a & {BANK_W{drive_en}};
            sink_b_reg <= on_b & {BANK_W{drive_en}};
            base_a_reg <= drive_en ? eff_a : '0;
            base_b_reg <= drive_en ? eff_b : '0;
        end
    end

    // open sense is only trusted while the output is sinking
    wire logic [BANK_W-1:0] open_a_hit = oa_sync & sink_a_reg;
    wire logic [BANK_W-1:0] open_b_hit = ob_sync & sink_b_reg;
    // sticky until read back; a new fault beats the clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            open_a_reg <= '0;
            open_b_reg <= '0;
        end else begin
            open_a_reg <=
                (open_a_reg & ~{BANK_W{load_evt}}) | open_a_hit;
            open_b_reg <=
                (open_b_reg & ~{BANK_W{load_evt}}) | open_b_hit;
        end
    end

    // apb decode; every access takes one wait state
    wire logic apb_acc = psel_i & penable_i;
    wire logic apb_first = apb_acc & ~pready_reg;
    wire logic apb_wr = apb_acc & pready_reg & pwrite_i;
    wire logic sel_stat = paddr_i == ADDR_IRQ_STAT;
    wire logic sel_mask = paddr_i == ADDR_IRQ_MASK;
    wire logic sel_fault = paddr_i == ADDR_FAULT;
    wire logic sel_cfg = paddr_i == ADDR_CONFIG;
    wire logic apb_hit = sel_stat | sel_mask | sel_fault | sel_cfg;
    wire logic [31:0] rd_fault = {14'h0, status_frame[F_ADDR_LO +: 18]};
    wire logic [31:0] rd_cfg = {14'h0, loaded_reg, wd_dis_reg, ramp_reg,
        coarse_b_reg, coarse_a_reg, div_reg};
    wire logic [31:0] rd_mux =
        sel_stat ? {28'h0, irq_stat_reg} :
        sel_mask ? {28'h0, irq_mask_reg} :
        sel_fault ? rd_fault :
        sel_cfg ? rd_cfg : 32'h0;

    // interrupt events, set wins over write-one-to-clear
    wire logic [IRQ_W-1:0] irq_evt;
    assign irq_evt[IRQ_LATCH] = copy_evt;
    assign irq_evt[IRQ_WD] = wd_expire & ~wd_trip_reg & ~sck_edge;
    assign irq_evt[IRQ_OPEN] = |({open_b_hit, open_a_hit} &
        ~{open_b_reg, open_a_reg});
    assign irq_evt[IRQ_THERM] = ot_sync & ~ot_prev;
    wire logic [IRQ_W-1:0] irq_clr =
        (apb_wr & sel_stat) ? pwdata_i[IRQ_W-1:0] : '0;

    // apb slave registers
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= apb_first;
            pslverr_reg <= apb_first & ~apb_hit;
            prdata_reg <= (apb_first & ~pwrite_i) ? rd_mux : '0;
        end
    end

    // interrupt status, mask and level output
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
            if (apb_wr & sel_mask) begin
                irq_mask_reg <= pwdata_i[IRQ_W-1:0];
            end
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign serial_data_out_o = sout_reg;
    assign bank_a_sink_output_o = sink_a_reg;
    assign bank_b_sink_output_o = sink_b_reg;
    assign bank_a_base_drive_o = base_a_reg;
    assign bank_b_base_drive_o = base_b_reg;
    assign irq_o = irq_reg;

    // checks on the design's own behaviour
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_copy;
        copy_evt ##1 (latch_reg == LATCH_COPIED);
    endsequence
    sequence s_load;
        load_evt ##1 (latch_reg == LATCH_HELD);
    endsequence

    a_shift_through: assert property (
        shift_evt |=> shift_reg[FRAME_W-1] == $past(din_sync)
    ) else $error("shift did not take serial input");
    a_single_copy: assert property (
        s_copy |-> !copy_evt throughout (lat_sync [*2])
    ) else $error("second copy in one strobe period");
    a_status_load: assert property (
        s_load |-> shift_reg[ALT_W+REV_W+BANK_W*2+1:BANK_W*2+2] ==
            {ALT_PATTERN, MASK_REV}
    ) else $error("status not loaded into shift register");
    a_chain_out: assert property (
        shift_evt |-> ##2 serial_data_out_o == $past(shift_reg[1], 2)
    ) else $error("serial out not the last stage");
    a_blank_reset: assert property (
        !loaded_reg |=> bank_a_sink_output_o == '0 &&
            bank_b_sink_output_o == '0
    ) else $error("output driven before settings loaded");
    a_wd_trip: assert property (
        (wd_expire && !wd_trip_reg && !sck_edge) |=> wd_trip_reg ##1
            (bank_a_sink_output_o == '0 && bank_b_sink_output_o == '0)
    ) else $error("watchdog timeout did not blank outputs");
    a_wd_disable: assert property (
        wd_dis_reg && !wd_trip_reg |=> !wd_trip_reg
    ) else $error("disabled watchdog tripped");
    a_thermal_off: assert property (
        ot_sync |=> bank_a_sink_output_o == '0 && base_b_reg == '0
    ) else $error("overtemperature left outputs on");
    a_soft_start: assert property (
        !drive_en |=> ramp_reg == '0 ##1 ramp_reg == '0
    ) else $error("ramp did not restart from zero");
    a_open_record: assert property (
        |open_a_hit |=> |open_a_reg
    ) else $error("open fault not recorded");
    a_irq_level: assert property (
        |(irq_stat_reg & irq_mask_reg) |=> irq_o
    ) else $error("unmasked status without interrupt");
endmodule

/* sim/lbd_ctrl_model.sv */
// display controller model driving the serial shift chain
`timescale 1ns/1ps
module lbd_ctrl_model (
    // clock
    input wire logic core_clk_i,
    // serial link
    input wire logic serial_data_out_i,
    output logic serial_shift_clock_o,
    output logic serial_data_in_o,
    output logic latch_strobe_o
);
    // half of the 160 ns link period, in core cycles
    localparam int HALF = 8;

    // link idles low, clock stands still outside frames
    initial begin
        serial_shift_clock_o = 1'b0;
        serial_data_in_o = 1'b0;
        latch_strobe_o = 1'b0;
    end

    task automatic half_wait();
        repeat (HALF) @(posedge core_clk_i);
    endtask

    // one whole frame, first bit lsb; old content returns on rx
    task automatic shift_frame(input logic [35:0] f, output logic [35:0] rx);
        @(posedge core_clk_i);
        for (int i = 0; i < 36; i++) begin
            serial_shift_clock_o <= 1'b0;
            serial_data_in_o <= f[i];
            half_wait();
            rx[i] = serial_data_out_i; // settled long before the rise
            serial_shift_clock_o <= 1'b1;
            half_wait();
        end
        // data hold has run out, so no stale value is left
        serial_data_in_o <= ~f[35];
    endtask

    // strobe high, then n fall/rise pairs; only the first pair counts
    task automatic latch_pulse(input int n);
        latch_strobe_o <= 1'b1;
        half_wait();
        repeat (n) begin
            serial_shift_clock_o <= 1'b0;
            half_wait();
            serial_shift_clock_o <= 1'b1;
            half_wait();
        end
        latch_strobe_o <= 1'b0;
        half_wait();
        serial_shift_clock_o <= 1'b0;
        half_wait();
    endtask
endmodule

/* sim/lbd_led_bank_driver_tb.sv */
// self-checking bench for the led bank serial driver
`timescale 1ns/1ps
module lbd_led_bank_driver_tb;
    import lbd_pkg::*;
    localparam int WD_SIM = 200;
    // status with no faults, first bit out is bit 0
    localparam logic [35:0] STAT0 = {ALT_PATTERN, MASK_REV, 18'h0};
    localparam logic [35:0] FA = 36'h5a3c96e17;
    // addr 0/1, duty 512 both banks, wd off except in FD, div 0, coarse 9 and 6
    localparam logic [35:0] FB =
        {4'h6, 4'h9, 4'h0, 1'b1, 10'h200, 10'h200, 3'h0};
    localparam logic [35:0] FC =
        {4'h6, 4'h9, 4'h0, 1'b1, 10'h200, 10'h200, 3'h1};
    localparam logic [35:0] FD =
        {4'h6, 4'h9, 4'h0, 1'b0, 10'h200, 10'h200, 3'h0};
    logic core_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [APB_AW-1:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic sck, sdi, latch, sdo, overtemp_i, irq_o, err;
    logic [BANK_W-1:0] open_a, open_b, out_a, out_b;
    logic [COARSE_W-1:0] bd_a, bd_b;
    logic [35:0] rx;
    int err_count, n_tests, cyc, c0, c1, c2, c3;

    lbd_led_bank_driver #(.WD_CYC(WD_SIM)) dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .serial_shift_clock_i(sck),
        .serial_data_in_i(sdi), .latch_strobe_i(latch),
        .serial_data_out_o(sdo), .open_sense_a_i(open_a),
        .open_sense_b_i(open_b), .overtemp_i(overtemp_i),
        .bank_a_sink_output_o(out_a), .bank_b_sink_output_o(out_b),
        .bank_a_base_drive_o(bd_a), .bank_b_base_drive_o(bd_b),
        .irq_o(irq_o));

    lbd_ctrl_model ctrl (
        .core_clk_i(core_clk_i), .serial_data_out_i(sdo),
        .serial_shift_clock_o(sck), .serial_data_in_o(sdi),
        .latch_strobe_o(latch));

    // 100 MHz core clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic end_of_test();
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard, well above the planned run length
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, seen, exp);
        end
    endtask

    // apb transfer; answer taken at the rise where pready is sampled high
    task automatic apb(input logic w, input logic [APB_AW-1:0] a,
                       input logic [31:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rdc(input logic [APB_AW-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk({4'h0, rd}, {4'h0, exp});
    endtask

    // one full pwm period at divisor 0
    task automatic pwm_count();
        c0 = 0;
        c1 = 0;
        c2 = 0;
        c3 = 0;
        repeat (1024) begin
            @(negedge core_clk_i);
            c0 += int'(out_a[0]);
            c1 += int'(out_a[0] ^ out_a[1]);
            c2 += int'(out_a[0] ^ out_b[0]);
            c3 += int'(out_b[0]);
        end
    endtask

    initial begin
        {rst_i, psel_i, penable_i, pwrite_i, overtemp_i} = 5'h10;
        paddr_i = '0;
        pwdata_i = 32'h0;
        open_a = 8'h00;
        open_b = 8'h00;
        err_count = 0;
        n_tests = 0;
        cyc = 0;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // plain shift register while strobe stays low
        ctrl.shift_frame(FA, rx);
        ctrl.shift_frame(FB, rx);
        chk(rx, FA);
        chk({out_a, out_b}, 16'h0);
        // extra fall while strobe high must not copy status over
        ctrl.latch_pulse(2);
        @(negedge core_clk_i);
        chk(bd_a, 4'h0);
        rdc(ADDR_CONFIG, 32'h00030690);
        rdc(ADDR_IRQ_STAT, 32'h1);
        ctrl.shift_frame(FC, rx);
        chk(rx, STAT0);
        ctrl.latch_pulse(1);
        pwm_count();
        chk(c0, 512);
        chk(c3, 512);
        chk(c1, 128);
        chk(c2, 64);
        // interrupt masking and clearing
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(negedge core_clk_i);
        chk(irq_o, 1'b1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(negedge core_clk_i);
        chk(irq_o, 1'b0);
        rdc(12'h010, 32'h0);
        chk(err, 1'b1);
        // open circuit on a sinking output is sticky
        open_a <= 8'h01;
        repeat (1100) @(posedge core_clk_i);
        open_a <= 8'h00;
        rdc(ADDR_FAULT, 32'h1);
        overtemp_i <= 1'b1;
        repeat (10) @(negedge core_clk_i);
        chk({out_a, out_b}, 16'h0);
        rdc(ADDR_FAULT, 32'h20001);
        overtemp_i <= 1'b0;
        rdc(ADDR_IRQ_STAT, 32'hc);
        // blanking restarted the ramp; wait for full coarse level
        repeat (16500) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk({bd_a, bd_b}, 8'h96);
        rdc(ADDR_CONFIG, 32'h0003f690);
        // watchdog enabled, then the link goes quiet
        ctrl.shift_frame(FD, rx);
        chk(rx, STAT0);
        ctrl.latch_pulse(1);
        repeat (150) @(posedge core_clk_i);
        rdc(ADDR_FAULT, 32'h0);
        repeat (100) @(posedge core_clk_i);
        rdc(ADDR_FAULT, 32'h10000);
        @(negedge core_clk_i);
        chk({out_a, out_b}, 16'h0);
        // open fault captured at the last load is read back
        ctrl.shift_frame(FB, rx);
        chk(rx, STAT0 | 36'h1);
        end_of_test();
    end
endmodule
